// ---- rtl/hic_pkg.sv ----
// package for the counter input and event configuration block
package hic_pkg;
  // byte offsets in the parameter record
  localparam logic [3:0] HIC_OFS_INPUT = 4'h6;
  localparam logic [3:0] HIC_OFS_INDEX = 4'h7;
  localparam logic [3:0] HIC_OFS_GATE = 4'h8;
  localparam logic [3:0] HIC_OFS_CMP = 4'h9;
  localparam logic [7:0] HIC_CFG_RESET = 8'h00;

  // reserved bits, must be written as zero
  localparam logic [7:0] HIC_RSV_INPUT = 8'hc0;
  localparam logic [7:0] HIC_RSV_INDEX = 8'h10;
  localparam logic [7:0] HIC_RSV_GATE = 8'he0;
  localparam logic [7:0] HIC_RSV_CMP = 8'h2a;

  // highest legal codes
  localparam logic [3:0] HIC_SIG_MAX = 4'h4;
  localparam logic [1:0] HIC_EVAL_MAX = 2'h2;
  localparam logic [3:0] HIC_FILT_MAX = 4'h9;
  localparam logic [1:0] HIC_IDX_MAX = 2'h2;

  // field positions in the input type byte
  localparam int HIC_SIG_LSB = 0;
  localparam int HIC_SIG_MSB = 3;
  localparam int HIC_EVAL_LSB = 4;
  localparam int HIC_EVAL_MSB = 5;

  // field positions in the index and filter byte
  localparam int HIC_FILT_LSB = 0;
  localparam int HIC_FILT_MSB = 3;
  localparam int HIC_INV_BIT = 5;
  localparam int HIC_IDX_LSB = 6;
  localparam int HIC_IDX_MSB = 7;

  // enable bit positions in the gate and limit byte
  localparam int HIC_EN_GATE_START = 0;
  localparam int HIC_EN_GATE_STOP = 1;
  localparam int HIC_EN_OVERFLOW = 2;
  localparam int HIC_EN_UNDERFLOW = 3;
  localparam int HIC_EN_DIR_REV = 4;

  // enable bit positions in the compare and capture byte
  localparam int HIC_EN_CMP_FIRST = 0;
  localparam int HIC_EN_CMP_SECOND = 2;
  localparam int HIC_EN_ZERO_CROSS = 4;
  localparam int HIC_EN_NEW_CAPTURE = 6;
  localparam int HIC_EN_EXT_SYNC = 7;

  typedef enum logic [3:0] {
    HIC_SIG_PULSE = 4'h0,
    HIC_SIG_PULSE_DIR = 4'h1,
    HIC_SIG_UP_DOWN = 4'h2,
    HIC_SIG_QUAD = 4'h3,
    HIC_SIG_QUAD_INDEX = 4'h4
  } hic_sig_type;

  typedef enum logic [1:0] {
    HIC_EVAL_SINGLE = 2'h0,
    HIC_EVAL_DOUBLE = 2'h1,
    HIC_EVAL_QUAD = 2'h2
  } hic_eval_type;

  typedef enum logic [1:0] {
    HIC_IDX_NONE = 2'h0,
    HIC_IDX_SYNC = 2'h1,
    HIC_IDX_CAPTURE = 2'h2
  } hic_idx_type;

  // counter events, one bit each
  typedef struct packed {
    logic ext_sync;
    logic new_capture;
    logic zero_cross;
    logic cmp_second;
    logic cmp_first;
    logic dir_reversal;
    logic underflow;
    logic overflow;
    logic gate_stop;
    logic gate_start;
  } hic_event_type;

  // diagnostic events
  typedef struct packed {
    logic hw_irq_lost;
    logic phase_ratio;
    logic supply_missing;
  } hic_diag_type;

  // decoded configuration for the counting core
  typedef struct packed {
    hic_sig_type sig;
    hic_eval_type eval;
    hic_idx_type idx;
    logic invert_dir;
    logic [3:0] filter;
  } hic_cfg_type;

  typedef struct packed {
    logic [7:0] input_type;
    logic [7:0] index_filter;
    logic [7:0] gate_limit;
    logic [7:0] cmp_capture;
    logic diag_enable;
    logic cfg_error;
    hic_event_type event_out;
    hic_diag_type diag_out;
  } hic_state_type;
endpackage

// ---- rtl/hic_config.sv ----
// counter input and event configuration registers with event gating
// Functional notes
// - diagnostic interrupts pass only while the additional-diagnostic enable is 1.
// - byte 6 selects signal type (codes 0..4) and edge evaluation (codes 0..2).
// - byte 7 bits 3..0 select the filter frequency, codes 0..9, above reserved.
// - byte 8 bits 0..4 enable gate start, gate stop, overflow, underflow, direction reversal.
// - byte 9 bits 0,2,4,6,7 enable compare first, compare second, zero, capture, ext sync.
`timescale 1ns/100ps
module hic_config
  import hic_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // record byte write port
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_diag_enable,
  // events from counting core
  input wire hic_event_type i_event,
  input wire hic_diag_type i_diag,
  // decoded configuration and gated events
  output hic_cfg_type o_cfg,
  output logic o_cfg_error,
  output hic_event_type o_event,
  output hic_diag_type o_diag
);
  hic_state_type state_reg;
  hic_state_type state_next;
  logic bad;

  always_comb begin
    state_next = state_reg;
    bad = 1'b0;
    if (i_wr_en) begin
      unique case (i_wr_addr)
        HIC_OFS_INPUT: begin
          bad = |(i_wr_data & HIC_RSV_INPUT)
            || i_wr_data[HIC_SIG_MSB:HIC_SIG_LSB] > HIC_SIG_MAX
            || i_wr_data[HIC_EVAL_MSB:HIC_EVAL_LSB] > HIC_EVAL_MAX;
          if (!bad) begin
            state_next.input_type = i_wr_data;
          end
        end
        HIC_OFS_INDEX: begin
          bad = |(i_wr_data & HIC_RSV_INDEX)
            || i_wr_data[HIC_FILT_MSB:HIC_FILT_LSB] > HIC_FILT_MAX
            || i_wr_data[HIC_IDX_MSB:HIC_IDX_LSB] > HIC_IDX_MAX;
          if (!bad) begin
            state_next.index_filter = i_wr_data;
          end
        end
        HIC_OFS_GATE: begin
          bad = |(i_wr_data & HIC_RSV_GATE);
          if (!bad) begin
            state_next.gate_limit = i_wr_data;
          end
        end
        HIC_OFS_CMP: begin
          bad = |(i_wr_data & HIC_RSV_CMP);
          if (!bad) begin
            state_next.cmp_capture = i_wr_data;
          end
        end
        default: bad = 1'b1;
      endcase
      // failed write keeps previous configuration
      state_next.cfg_error = bad;
    end
    state_next.diag_enable = i_diag_enable;
    // events gated by the enables stored before this cycle
    state_next.event_out.gate_start = i_event.gate_start
      & state_reg.gate_limit[HIC_EN_GATE_START];
    state_next.event_out.gate_stop = i_event.gate_stop
      & state_reg.gate_limit[HIC_EN_GATE_STOP];
    state_next.event_out.overflow = i_event.overflow
      & state_reg.gate_limit[HIC_EN_OVERFLOW];
    state_next.event_out.underflow = i_event.underflow
      & state_reg.gate_limit[HIC_EN_UNDERFLOW];
    state_next.event_out.dir_reversal = i_event.dir_reversal
      & state_reg.gate_limit[HIC_EN_DIR_REV];
    state_next.event_out.cmp_first = i_event.cmp_first
      & state_reg.cmp_capture[HIC_EN_CMP_FIRST];
    state_next.event_out.cmp_second = i_event.cmp_second
      & state_reg.cmp_capture[HIC_EN_CMP_SECOND];
    state_next.event_out.zero_cross = i_event.zero_cross
      & state_reg.cmp_capture[HIC_EN_ZERO_CROSS];
    state_next.event_out.new_capture = i_event.new_capture
      & state_reg.cmp_capture[HIC_EN_NEW_CAPTURE];
    state_next.event_out.ext_sync = i_event.ext_sync
      & state_reg.cmp_capture[HIC_EN_EXT_SYNC];
    state_next.diag_out = state_reg.diag_enable ? i_diag : '0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // only legal codes are ever stored, so the casts cannot meet a reserved code
  assign o_cfg.sig = hic_sig_type'(state_reg.input_type[HIC_SIG_MSB:HIC_SIG_LSB]);
  assign o_cfg.eval = hic_eval_type'(state_reg.input_type[HIC_EVAL_MSB:HIC_EVAL_LSB]);
  assign o_cfg.idx = hic_idx_type'(state_reg.index_filter[HIC_IDX_MSB:HIC_IDX_LSB]);
  assign o_cfg.invert_dir = state_reg.index_filter[HIC_INV_BIT];
  assign o_cfg.filter = state_reg.index_filter[HIC_FILT_MSB:HIC_FILT_LSB];
  assign o_cfg_error = state_reg.cfg_error;
  assign o_event = state_reg.event_out;
  assign o_diag = state_reg.diag_out;
endmodule

// ---- dv/hic_src.sv ----
// event source standing in for the counting core
`timescale 1ns/100ps
module hic_src
  import hic_pkg::*;
(
  input wire logic [12:0] i_pat,
  output hic_event_type o_event,
  output hic_diag_type o_diag
);
  assign {o_event, o_diag} = i_pat;
endmodule

// ---- dv/hic_chk.sv ----
// port assertions for the configuration block
`timescale 1ns/100ps
module hic_chk
  import hic_pkg::*;
(
  input wire logic i_clk, i_rst_n, i_wr_en, i_diag_enable, o_cfg_error,
  input wire logic [3:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire hic_event_type i_event, o_event,
  input wire hic_diag_type i_diag, o_diag,
  input wire hic_cfg_type o_cfg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] d_q;
  always_ff @(posedge i_clk) d_q <= i_wr_data;
  wire logic w6 = i_wr_en && i_wr_addr == 4'h6;
  wire logic w7 = i_wr_en && i_wr_addr == 4'h7;
  a_diag_gate: assert property (!$past(i_diag_enable, 2) |-> o_diag == '0)
    else $error("diag ungated");
  a_sig_refuse: assert property (w6 && (i_wr_data[3:0] > 4'h4 || i_wr_data[5:4] == 2'h3)
    |=> o_cfg_error && $stable(o_cfg)) else $error("type kept");
  a_filt_refuse: assert property (w7 && i_wr_data[3:0] > 4'h9
    |=> o_cfg_error && $stable(o_cfg)) else $error("filter kept");
  a_idx_store: assert property (w7 && i_wr_data[4:0] < 5'ha && i_wr_data[7:6] != 2'h3
    |=> o_cfg[6:0] == {d_q[7:5], d_q[3:0]}) else $error("index lost");
  a_gate_pass: assert property (i_wr_en && i_wr_addr == 4'h8 && i_wr_data[7:5] == 3'h0
    && i_wr_data[0] ##1 !i_wr_en ##1 i_event[0] |=> o_event[0]) else $error("start lost");
  a_no_cause: assert property ((o_event & ~$past(i_event)) == '0)
    else $error("event uncaused");
  c_refuse: cover property (o_cfg_error);
  c_event: cover property (o_event != '0);
  c_diag: cover property (o_diag != '0);
endmodule
bind hic_config hic_chk i_chk (.*);

// ---- dv/tb_hic_config.sv ----
// random self-checking bench for the configuration block
`timescale 1ns/100ps
module tb_hic_config;
  import hic_pkg::*;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_wr_en = 1'h0, i_diag_enable = 1'h0, o_cfg_error;
  logic err = 1'h0, en_q = 1'h0;
  logic [3:0] i_wr_addr = 4'h0, a;
  logic [7:0] i_wr_data = 8'h00, d, m [6:9] = '{default: 8'h00};
  logic [12:0] pat = 13'h0000, ex;
  logic [26:0] exp_q [$];
  logic [31:0] r;
  hic_event_type i_event, o_event;
  hic_diag_type i_diag, o_diag;
  hic_cfg_type o_cfg;
  integer seed = 37400, fails = 0, check_count = 0;
  always #50 i_clk = ~i_clk;
  hic_src i_hic_src (.i_pat(pat), .o_event(i_event), .o_diag(i_diag));
  hic_config i_hic_config (.*);
  function automatic logic legal(logic [3:0] a, logic [7:0] d);
    return a == 4'h6 ? d[7:6] == 2'h0 && d[3:0] < 4'h5 && d[5:4] != 2'h3 :
      a == 4'h7 ? d[4:0] < 5'ha && d[7:6] != 2'h3 :
      a == 4'h8 ? d[7:5] == 3'h0 : a == 4'h9 && (d & 8'h2a) == 8'h00;
  endfunction
  task automatic check(input logic [26:0] seen, input logic [26:0] want);
    check_count++;
    if (seen !== want) $display("ERROR %0t got %h want %h", $time, seen, want);
    if (seen !== want) fails++;
  endtask
  task automatic stop_test;
    $display("%0d checks, %0d mismatches", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge i_clk) if (exp_q.size() > 0)
    check({o_cfg_error, o_cfg, o_event, o_diag}, exp_q.pop_front());
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    repeat (1500) begin
      r = $random(seed);
      a = 4'h5 + 4'(r[7:5] % 3'h6);
      d = r[15:8] & (r[3] ? 8'h0f : 8'hff);
      {i_wr_en, i_wr_addr, i_wr_data} <= {r[4], a, d};
      {i_diag_enable, pat} <= r[29:16];
      ex = {r[28:19] & {m[9][7:6], m[9][4], m[9][2], m[9][0], m[8][4:0]}, r[18:16] & {3{en_q}}};
      en_q = r[29];
      if (r[4]) err = !legal(a, d);
      if (r[4] && !err) m[a] = d;
      @(posedge i_clk);
      exp_q.push_back({err, m[6][3:0], m[6][5:4], m[7][7:5], m[7][3:0], ex});
    end
    repeat (2) @(negedge i_clk);
    $display("random configuration test done");
    stop_test();
  end
  initial #200000 begin
    fails++;
    stop_test();
  end
endmodule
